// ---- pkg/ssi_pkg.sv ----
// shared constants and types for the switch state indicator
package ssi_pkg;
    typedef enum logic [1:0] {
        SSI_V1X2,
        SSI_V2X2,
        SSI_V1X4,
        SSI_V1X8
    } ssi_variant_e;

    typedef enum logic [1:0] {
        SSI_NV_IDLE,
        SSI_NV_READ,
        SSI_NV_WAIT,
        SSI_NV_RUN
    } ssi_nv_state_e;

    localparam int          STATE_W          = 3;
    localparam logic [2:0]  STATE_RESET      = 3'h0;
    localparam logic [3:0]  NV_DATA_RESET    = 4'h1;
    localparam logic [7:0]  LINES_RESET      = 8'h00;
    localparam logic [6:0]  SEG_RESET        = 7'h00;
    localparam logic [7:0]  LINES_2X2_BAR    = 8'h21;
    localparam logic [7:0]  LINES_2X2_CROSS  = 8'h12;
    localparam int          DEBOUNCE_MS      = 10;
    localparam int          CLK_HZ           = 20000000;
    localparam int          DEBOUNCE_CYCLES  = (CLK_HZ / 1000) * DEBOUNCE_MS;
endpackage

// ---- hw/ssi_debounce.sv ----
// push button debouncer with single press pulse
`timescale 1ns/100ps
module ssi_debounce #(
    parameter int COUNT = 200000
) (
    input  wire logic clk_sys_i,
    input  wire logic reset_i,
    input  wire logic button_n_i,
    output logic      press_o
);
    localparam int CW = $clog2(COUNT + 1);

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          stable_n;
    logic          next_stable_n;
    logic          press;
    logic          next_press;

    always_comb begin
        next_cnt      = cnt;
        next_stable_n = stable_n;
        next_press    = 1'b0;
        if (button_n_i == stable_n) begin
            next_cnt = '0;
        end else if (cnt == CW'(COUNT - 1)) begin
            next_cnt      = '0;
            next_stable_n = button_n_i;
            next_press    = ~button_n_i;
        end else begin
            next_cnt = cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            cnt      <= '0;
            stable_n <= 1'b1;
            press    <= 1'b0;
        end else begin
            cnt      <= next_cnt;
            stable_n <= next_stable_n;
            press    <= next_press;
        end
    end

    assign press_o = press;
endmodule // ssi_debounce

// ---- hw/ssi_top.sv ----
// switch state holder with indicator, status lines and nonvolatile copy
`timescale 1ns/100ps
module ssi_top #(
    parameter ssi_pkg::ssi_variant_e VARIANT  = ssi_pkg::SSI_V1X2,
    parameter int                    DEBOUNCE = ssi_pkg::DEBOUNCE_CYCLES
) (
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    input  wire logic       trigger_i,
    input  wire logic       button_n_i,
    input  wire logic [3:0] nv_rd_data_i,
    input  wire logic       nv_rd_valid_i,
    output logic            nv_rd_req_o,
    output logic            nv_wr_o,
    output logic [3:0]      nv_wr_data_o,
    output logic [6:0]      state_indicator_o,
    output logic [7:0]      state_lines_o,
    output logic [1:0]      switch_sel_o,
    output logic            ready_o
);
    // state is held zero-based: 0 means state 1
    function automatic logic [2:0] last_state(input ssi_pkg::ssi_variant_e v);
        case (v)
            ssi_pkg::SSI_V1X4: last_state = 3'h3;
            ssi_pkg::SSI_V1X8: last_state = 3'h7;
            default:           last_state = 3'h1;
        endcase
    endfunction

    function automatic logic [7:0] lines_of(input logic [2:0] s);
        logic [7:0] l;
        l = 8'h01 << s;
        if (VARIANT == ssi_pkg::SSI_V2X2) begin
            l = s[0] ? ssi_pkg::LINES_2X2_CROSS : ssi_pkg::LINES_2X2_BAR;
        end
        lines_of = l;
    endfunction

    function automatic logic [6:0] seg_of(input logic [2:0] s);
        case (s)
            3'h0:    seg_of = 7'h06;
            3'h1:    seg_of = 7'h5B;
            3'h2:    seg_of = 7'h4F;
            3'h3:    seg_of = 7'h66;
            3'h4:    seg_of = 7'h6D;
            3'h5:    seg_of = 7'h7D;
            3'h6:    seg_of = 7'h07;
            default: seg_of = 7'h7F;
        endcase
    endfunction

    localparam logic [2:0] LAST = last_state(VARIANT);

    logic                  press;
    logic                  trig_s1;
    logic                  trig_s2;
    logic                  trig_d;
    logic                  next_trig_s1;
    logic                  next_trig_s2;
    logic                  next_trig_d;
    ssi_pkg::ssi_nv_state_e nv_st;
    ssi_pkg::ssi_nv_state_e next_nv_st;
    logic [2:0]            state;
    logic [2:0]            next_state;
    logic                  rd_req;
    logic                  next_rd_req;
    logic                  wr;
    logic                  next_wr;
    logic [3:0]            wr_data;
    logic [3:0]            next_wr_data;
    logic [6:0]            seg;
    logic [6:0]            next_seg;
    logic [7:0]            lines;
    logic [7:0]            next_lines;
    logic                  ready;
    logic                  next_ready;
    logic                  step;

    ssi_debounce #(
        .COUNT      (DEBOUNCE)
    ) u_debounce (
        .clk_sys_i  (clk_sys_i),
        .reset_i    (reset_i),
        .button_n_i (button_n_i),
        .press_o    (press)
    );

    // trigger synchroniser and falling edge
    always_comb begin
        next_trig_s1 = trigger_i;
        next_trig_s2 = trig_s1;
        next_trig_d  = trig_s2;
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            trig_s1 <= 1'b1;
            trig_s2 <= 1'b1;
            trig_d  <= 1'b1;
        end else begin
            trig_s1 <= next_trig_s1;
            trig_s2 <= next_trig_s2;
            trig_d  <= next_trig_d;
        end
    end

    assign step = (trig_d & ~trig_s2) | press;

    // restore, step and save
    always_comb begin
        next_nv_st   = nv_st;
        next_state   = state;
        next_rd_req  = 1'b0;
        next_wr      = 1'b0;
        next_wr_data = wr_data;
        next_ready   = ready;
        case (nv_st)
            ssi_pkg::SSI_NV_IDLE: begin
                next_rd_req = 1'b1;
                next_nv_st  = ssi_pkg::SSI_NV_READ;
            end
            ssi_pkg::SSI_NV_READ: begin
                next_nv_st = ssi_pkg::SSI_NV_WAIT;
            end
            ssi_pkg::SSI_NV_WAIT: begin
                if (nv_rd_valid_i) begin
                    // stored as state number 1..8
                    if (nv_rd_data_i == 4'h0 || (nv_rd_data_i - 4'h1) > {1'b0, LAST}) begin
                        next_state = ssi_pkg::STATE_RESET;
                    end else begin
                        next_state = 3'(nv_rd_data_i - 4'h1);
                    end
                    next_ready = 1'b1;
                    next_nv_st = ssi_pkg::SSI_NV_RUN;
                end
            end
            ssi_pkg::SSI_NV_RUN: begin
                if (step) begin
                    next_state   = (state == LAST) ? 3'h0 : state + 3'h1;
                    next_wr      = 1'b1;
                    next_wr_data = {1'b0, next_state} + 4'h1;
                end
            end
            default: next_nv_st = ssi_pkg::SSI_NV_IDLE;
        endcase
        next_seg   = ready ? seg_of(state) : ssi_pkg::SEG_RESET;
        next_lines = ready ? lines_of(state) : ssi_pkg::LINES_RESET;
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            nv_st   <= ssi_pkg::SSI_NV_IDLE;
            state   <= ssi_pkg::STATE_RESET;
            rd_req  <= 1'b0;
            wr      <= 1'b0;
            wr_data <= ssi_pkg::NV_DATA_RESET;
            seg     <= ssi_pkg::SEG_RESET;
            lines   <= ssi_pkg::LINES_RESET;
            ready   <= 1'b0;
        end else begin
            nv_st   <= next_nv_st;
            state   <= next_state;
            rd_req  <= next_rd_req;
            wr      <= next_wr;
            wr_data <= next_wr_data;
            seg     <= next_seg;
            lines   <= next_lines;
            ready   <= next_ready;
        end
    end

    assign nv_rd_req_o       = rd_req;
    assign nv_wr_o           = wr;
    assign nv_wr_data_o      = wr_data;
    assign state_indicator_o = seg;
    assign state_lines_o     = lines;
    assign switch_sel_o      = state[1:0];
    assign ready_o           = ready;

    a_lines_onehot: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (ready && VARIANT != ssi_pkg::SSI_V2X2) |=> $onehot(state_lines_o))
        else $error("status lines not one-hot");
    a_lines_match: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ready |=> (state_lines_o == lines_of($past(state))))
        else $error("status lines do not follow state");
    a_step_saves: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (nv_st == ssi_pkg::SSI_NV_RUN && step)
        |=> (nv_wr_o && nv_wr_data_o == {1'b0, state} + 4'h1))
        else $error("state change not saved");
    a_state_range: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        state <= LAST)
        else $error("state beyond variant range");
    a_step_wraps: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (nv_st == ssi_pkg::SSI_NV_RUN && step && state == LAST) |=> state == 3'h0)
        else $error("state did not wrap");
    a_restore_bad: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (nv_st == ssi_pkg::SSI_NV_WAIT && nv_rd_valid_i && nv_rd_data_i == 4'h0)
        |=> state == 3'h0)
        else $error("bad restore not forced to state one");
    a_seg_follow: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ready |=> state_indicator_o == seg_of($past(state)))
        else $error("indicator does not follow state");
    a_no_step_idle: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (nv_st == ssi_pkg::SSI_NV_RUN && !step) |=> ($stable(state) && !nv_wr_o))
        else $error("state changed without event");
endmodule // ssi_top

// ---- dv/ssi_nv_model.sv ----
// nonvolatile store model answering restore reads and keeping writes
`timescale 1ns/100ps
module ssi_nv_model #(
    parameter int DELAY = 3
) (
    input  wire logic       clk_sys_i,
    input  wire logic       load_i,
    input  wire logic [3:0] load_data_i,
    input  wire logic       rd_req_i,
    input  wire logic       wr_i,
    input  wire logic [3:0] wr_data_i,
    output logic [3:0]      rd_data_o,
    output logic            rd_valid_o
);
    logic [3:0] mem;
    int         wait_cnt = 0;

    always @(posedge clk_sys_i) begin
        if (load_i) begin
            mem <= load_data_i;
        end else if (wr_i) begin
            mem <= wr_data_i;
        end
        if (rd_req_i) begin
            wait_cnt <= DELAY;
        end else if (wait_cnt > 0) begin
            wait_cnt <= wait_cnt - 1;
        end
    end

    // data is only meaningful with the valid pulse
    assign rd_valid_o = (wait_cnt == 1);
    assign rd_data_o  = rd_valid_o ? mem : ~mem;
endmodule // ssi_nv_model

// ---- dv/ssi_top_bench.sv ----
// self-checking bench for the switch state holder, 1x8 build
`timescale 1ns/100ps
module ssi_top_bench;
    logic        clk_sys_i = 1'b0;
    logic        reset_i, trigger_i, button_n_i, load_i;
    logic [3:0]  load_data, nv_rd_data_i, nv_wr_data_o, wr_seen;
    logic        nv_rd_valid_i, nv_rd_req_o, nv_wr_o, ready_o, got_wr;
    logic [6:0]  state_indicator_o;
    logic [7:0]  state_lines_o;
    logic [1:0]  switch_sel_o;
    int          bad_count = 0;
    int          checks = 0;
    int          cycles = 0;
    // indicator segments, state number and status lines per step
    logic [19:0] rows [9] = '{20'h7F880, 20'h06101, 20'h5B202, 20'h4F304, 20'h66408,
                              20'h6D510, 20'h7D620, 20'h07740, 20'h7F880};

    always #25 clk_sys_i = ~clk_sys_i;

    ssi_top #(
        .VARIANT  (ssi_pkg::SSI_V1X8),
        .DEBOUNCE (4)
    ) u_dut (
        .clk_sys_i         (clk_sys_i),
        .reset_i           (reset_i),
        .trigger_i         (trigger_i),
        .button_n_i        (button_n_i),
        .nv_rd_data_i      (nv_rd_data_i),
        .nv_rd_valid_i     (nv_rd_valid_i),
        .nv_rd_req_o       (nv_rd_req_o),
        .nv_wr_o           (nv_wr_o),
        .nv_wr_data_o      (nv_wr_data_o),
        .state_indicator_o (state_indicator_o),
        .state_lines_o     (state_lines_o),
        .switch_sel_o      (switch_sel_o),
        .ready_o           (ready_o)
    );

    ssi_nv_model u_nv (
        .clk_sys_i   (clk_sys_i),
        .load_i      (load_i),
        .load_data_i (load_data),
        .rd_req_i    (nv_rd_req_o),
        .wr_i        (nv_wr_o),
        .wr_data_i   (nv_wr_data_o),
        .rd_data_o   (nv_rd_data_i),
        .rd_valid_o  (nv_rd_valid_i)
    );

    task automatic final_report();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        while (ready_o !== 1'b1 && n < 50) begin
            @(negedge clk_sys_i);
            n++;
        end
        @(negedge clk_sys_i);
    endtask

    // one falling trigger edge or button press, up to the line update
    task automatic step(input bit use_btn);
        int n;
        n = 0;
        got_wr = 1'b0;
        if (use_btn) begin
            button_n_i <= 1'b0;
        end else begin
            trigger_i <= 1'b0;
        end
        while (got_wr !== 1'b1 && n < 40) begin
            @(negedge clk_sys_i);
            got_wr = nv_wr_o;
            wr_seen = nv_wr_data_o;
            n++;
        end
        @(negedge clk_sys_i);
    endtask

    // mid-run reset with optional store preload, up to restore done
    task automatic restart(input bit ld, input logic [3:0] val, input logic trig);
        @(posedge clk_sys_i);
        reset_i <= 1'b1;
        load_i <= ld;
        load_data <= val;
        repeat (2) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        load_i <= 1'b0;
        trigger_i <= trig;
        wait_ready();
    endtask

    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            final_report();
        end
    end

    initial begin
        reset_i = 1'b1;
        trigger_i = 1'b1;
        button_n_i = 1'b1;
        load_i = 1'b1;
        load_data = 4'h7;
        repeat (8) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        load_i <= 1'b0;
        wait_ready();
        check({7'h0, ready_o}, 8'h01);
        check(state_lines_o, 8'h40);
        check({1'b0, state_indicator_o}, 8'h07);
        for (int i = 0; i < 9; i++) begin
            @(posedge clk_sys_i);
            step(i == 4);
            check({7'h0, got_wr}, 8'h01);
            check({4'h0, wr_seen}, {4'h0, rows[i][11:8]});
            check(state_lines_o, rows[i][7:0]);
            check({1'b0, state_indicator_o}, rows[i][19:12]);
            check({6'h0, switch_sel_o}, {6'h0, 2'(rows[i][11:8] - 4'h1)});
            @(posedge clk_sys_i);
            trigger_i <= 1'b1;
            button_n_i <= 1'b1;
            repeat (8) @(posedge clk_sys_i);
        end
        // last saved state 8 comes back after a reset
        restart(1'b0, 4'h0, 1'b1);
        check(state_lines_o, 8'h80);
        check({1'b0, state_indicator_o}, 8'h7F);
        // stored number above the variant range
        restart(1'b1, 4'h9, 1'b1);
        check(state_lines_o, 8'h01);
        // illegal stored value, trigger fall before restore completes
        restart(1'b1, 4'h0, 1'b0);
        check({7'h0, ready_o}, 8'h01);
        check(state_lines_o, 8'h01);
        check({1'b0, state_indicator_o}, 8'h06);
        final_report();
    end
endmodule // ssi_top_bench
